/* fmc_pkg.sv */
package fmc_pkg;

  localparam logic [7:0] CONFIG_OFS = 8'h03;
  localparam logic [7:0] ONE_SHOT_OFS = 8'h0f;
  localparam logic [7:0] CRIT_LIMIT_OFS = 8'h19;
  localparam logic [7:0] TACH_LOW_OFS = 8'h46;
  localparam logic [7:0] TACH_HIGH_OFS = 8'h47;

  localparam int ALERT_MASK_BIT = 7;
  localparam int LOW_POWER_HOLD_BIT = 6;
  localparam int STANDBY_PWM_OFF_BIT = 5;
  localparam int TACH_INPUT_ON_BIT = 2;
  localparam int CRIT_LIMIT_UNLOCK_BIT = 1;
  localparam int REMOTE_FAULT_QUEUE_BIT = 0;

  localparam logic [7:0] CONFIG_WRITE_MASK = 8'he7;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CRIT_LIMIT_RESET = 8'h6e;
  localparam logic [1:0] EDGE_SELECT_RESET = 2'h0;
  localparam logic [13:0] TACH_COUNT_RESET = 14'h3fff;
  localparam logic [13:0] TACH_COUNT_MAX = 14'h3fff;
  localparam logic [1:0] FAULT_QUEUE_DEPTH = 2'h3;
  localparam int TACH_TICK_DIV = 40;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fmc_reg_req_t;

  typedef struct packed {
    logic valid;
    logic high;
    logic low;
  } fmc_conv_result_t;

endpackage : fmc_pkg

/* fmc_config_tach.sv */
`timescale 1ns/100ps
// Functional notes
// - alert mask set blocks alerts and leaves alert pin released.
// - standby clear means continuous conversion, comparison and PWM updates.
// - standby set stops periodic conversions and comparisons.
// - in standby any one-shot register write starts exactly one conversion.
// - in standby, PWM continues or goes to polarity off level per bit.
// - configuration bits four and three ignore writes and read zero.
// - tach input measured only while tach enable bit is one.
// - critical limit locked at power-on value 110 while unlock bit clear.
// - critical limit writable any number of times while unlock bit set.
// - fault queue off: any single out-of-limit remote result raises alert.
// - fault queue on: three consecutive out-of-limit results raise alert.
// - low byte read freezes high byte; host reads low first.
// - count upper bits in high register, lower six in low bits 7:2.
// - tach high byte at higher address, low byte at lower address.
// - edge select: 01 two edges x4, 10 three x2, 11 five x1.
module fmc_config_tach
  import fmc_pkg::*;
#(
  parameter int TICK_DIV = TACH_TICK_DIV
) (
  input wire logic clk,
  input wire logic reset,
  input fmc_reg_req_t regReq,
  output logic [7:0] regRdata,
  output logic regRvalid,
  output logic convStart,
  input fmc_conv_result_t convResult,
  input wire logic tachPin,
  input wire logic pwmRaw,
  input wire logic pwmPolarity,
  output logic pwmOut,
  output logic alertOut,
  output logic alertOe,
  output logic [7:0] critLimit
);

  typedef enum logic [1:0] {CONV_IDLE, CONV_BUSY} fmc_conv_state_t;

  logic [7:0] devConfig;
  logic [1:0] edgeSelect;
  logic [7:0] highFrozen;
  logic [13:0] tachCount;
  logic [13:0] periodAcc;
  logic [2:0] edgesSeen;
  logic tachSync1;
  logic tachSync2;
  logic tachPrev;
  logic [$clog2(TICK_DIV+1)-1:0] tickCnt;
  logic tick;
  logic oneShotPending;
  logic [1:0] faultRun;
  logic alertActive;
  fmc_conv_state_t convState;

  wire standby = devConfig[LOW_POWER_HOLD_BIT];
  wire wrHit = regReq.write;

  function automatic logic [2:0] edges_needed(input logic [1:0] sel);
    unique case (sel)
      2'h2: edges_needed = 3'h3;
      2'h3: edges_needed = 3'h5;
      default: edges_needed = 3'h2;
    endcase
  endfunction : edges_needed

  function automatic logic [13:0] count_step(input logic [1:0] sel);
    unique case (sel)
      2'h2: count_step = 14'h0002;
      2'h3: count_step = 14'h0001;
      default: count_step = 14'h0004;
    endcase
  endfunction : count_step

  // saturate so a fan too slow for the range reads full scale rather than wrapping; a stalled fan keeps its last count
  function automatic logic [13:0] acc_next(input logic [13:0] acc, input logic [1:0] sel);
    if (acc > TACH_COUNT_MAX - count_step(sel)) begin
      acc_next = TACH_COUNT_MAX;
    end else begin
      acc_next = acc + count_step(sel);
    end
  endfunction : acc_next

  // register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      devConfig <= CONFIG_RESET;
      edgeSelect <= EDGE_SELECT_RESET;
      critLimit <= CRIT_LIMIT_RESET;
    end else if (wrHit) begin
      if (regReq.addr == CONFIG_OFS) begin
        devConfig <= regReq.wdata & CONFIG_WRITE_MASK;
      end
      if (regReq.addr == TACH_LOW_OFS) begin
        edgeSelect <= regReq.wdata[1:0];
      end
      if (regReq.addr == CRIT_LIMIT_OFS && devConfig[CRIT_LIMIT_UNLOCK_BIT]) begin
        critLimit <= regReq.wdata;
      end
    end
  end

  // register reads, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      regRdata <= 8'h00;
      regRvalid <= 1'b0;
      highFrozen <= 8'h00;
    end else begin
      regRvalid <= regReq.read;
      if (regReq.read) begin
        unique case (regReq.addr)
          CONFIG_OFS: regRdata <= devConfig;
          CRIT_LIMIT_OFS: regRdata <= critLimit;
          TACH_LOW_OFS: begin
            regRdata <= {tachCount[5:0], edgeSelect};
            highFrozen <= tachCount[13:6];
          end
          TACH_HIGH_OFS: regRdata <= highFrozen;
          default: regRdata <= 8'h00;
        endcase
      end
    end
  end

  // tach pin crosses in through two flops
  always_ff @(posedge clk) begin
    if (reset) begin
      tachSync1 <= 1'b0;
      tachSync2 <= 1'b0;
      tachPrev <= 1'b0;
    end else begin
      tachSync1 <= tachPin;
      tachSync2 <= tachSync1;
      tachPrev <= tachSync2;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || tickCnt == ($clog2(TICK_DIV+1))'(TICK_DIV - 1)) begin
      tickCnt <= '0;
    end else begin
      tickCnt <= tickCnt + 1'b1;
    end
  end
  assign tick = (tickCnt == ($clog2(TICK_DIV+1))'(TICK_DIV - 1));

  // period measurement between the selected number of rising edges
  always_ff @(posedge clk) begin
    if (reset) begin
      tachCount <= TACH_COUNT_RESET;
      periodAcc <= '0;
      edgesSeen <= '0;
    end else if (!devConfig[TACH_INPUT_ON_BIT]) begin
      periodAcc <= '0;
      edgesSeen <= '0;
    end else if (tachSync2 && !tachPrev) begin
      // a tick on the edge cycle still counts, so the reading does not depend on phase
      if (edgesSeen + 3'h1 >= edges_needed(edgeSelect)) begin
        tachCount <= periodAcc;
        periodAcc <= tick ? count_step(edgeSelect) : '0;
        edgesSeen <= 3'h1;
      end else begin
        if (edgesSeen == 3'h0) begin
          periodAcc <= tick ? count_step(edgeSelect) : '0;
        end else if (tick) begin
          periodAcc <= acc_next(periodAcc, edgeSelect);
        end
        edgesSeen <= edgesSeen + 3'h1;
      end
    end else if (tick && edgesSeen != 3'h0) begin
      periodAcc <= acc_next(periodAcc, edgeSelect);
    end
  end

  // one-shot request; set wins over the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      oneShotPending <= 1'b0;
    end else if (wrHit && regReq.addr == ONE_SHOT_OFS && standby) begin
      oneShotPending <= 1'b1;
    end else if (convState == CONV_IDLE) begin
      oneShotPending <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      convState <= CONV_IDLE;
      convStart <= 1'b0;
    end else begin
      convStart <= 1'b0;
      unique case (convState)
        CONV_IDLE: begin
          if (!standby || oneShotPending) begin
            convStart <= 1'b1;
            convState <= CONV_BUSY;
          end
        end
        CONV_BUSY: begin
          if (convResult.valid) begin
            convState <= CONV_IDLE;
          end
        end
      endcase
    end
  end

  // consecutive out-of-limit results
  always_ff @(posedge clk) begin
    if (reset) begin
      faultRun <= 2'h0;
      alertActive <= 1'b0;
    end else if (convResult.valid) begin
      if (convResult.high || convResult.low) begin
        if (faultRun != FAULT_QUEUE_DEPTH) begin
          faultRun <= faultRun + 2'h1;
        end
        if (!devConfig[REMOTE_FAULT_QUEUE_BIT] || faultRun >= FAULT_QUEUE_DEPTH - 2'h1) begin
          alertActive <= 1'b1;
        end
      end else begin
        faultRun <= 2'h0;
        alertActive <= 1'b0;
      end
    end
  end

  // open-drain alert pin pulled low while driven
  always_ff @(posedge clk) begin
    if (reset) begin
      alertOe <= 1'b0;
    end else begin
      alertOe <= alertActive && !devConfig[ALERT_MASK_BIT];
    end
  end
  assign alertOut = 1'b0;

  always_ff @(posedge clk) begin
    if (reset) begin
      pwmOut <= 1'b0;
    end else if (standby && devConfig[STANDBY_PWM_OFF_BIT]) begin
      pwmOut <= pwmPolarity;
    end else begin
      pwmOut <= pwmRaw;
    end
  end

endmodule : fmc_config_tach

/* fmc_config_tach_assertions.sv */
`timescale 1ns/100ps
module fmc_config_tach_assertions
  import fmc_pkg::*;
#(
  parameter int TICK_DIV = TACH_TICK_DIV
) (
  input logic clk,
  input logic reset,
  input fmc_reg_req_t regReq,
  input logic [7:0] regRdata,
  input logic convStart,
  input fmc_conv_result_t convResult,
  input logic pwmRaw,
  input logic pwmPolarity,
  input logic pwmOut,
  input logic alertOe,
  input logic [7:0] critLimit
);
  logic [7:0] cfg;
  logic shot;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  always_ff @(posedge clk) begin
    if (reset) cfg <= '0;
    else if (regReq.write && regReq.addr == CONFIG_OFS) cfg <= regReq.wdata & CONFIG_WRITE_MASK;
  end
  // set wins over clear, as in the design
  always_ff @(posedge clk) begin
    if (reset) shot <= 1'b0;
    else if (regReq.write && regReq.addr == ONE_SHOT_OFS && cfg[6]) shot <= 1'b1;
    else if (convStart) shot <= 1'b0;
  end
  AST_CFG_READ: assert property ($past(regReq.read && regReq.addr == CONFIG_OFS) |-> regRdata == $past(cfg))
    else $error("config readback wrong");
  AST_PWM_PATH: assert property (!$past(reset) |->
    pwmOut == ($past(cfg[6] && cfg[5]) ? $past(pwmPolarity) : $past(pwmRaw)))
    else $error("pwm output wrong");
  AST_CONV_RUN: assert property (convResult.valid && !cfg[6] ##1 !cfg[6] |-> ##[0:1] convStart)
    else $error("no restart when running");
  AST_LOW_POWER_HOLD_QUIET: assert property (convStart && $past(cfg[6]) |-> $past(shot))
    else $error("start in standby");
  AST_CRIT_LOCK: assert property (!$past(reset) && !$past(cfg[1]) |-> $stable(critLimit))
    else $error("locked limit moved");
  AST_CRIT_WR: assert property ($past(cfg[1] && regReq.write && regReq.addr == CRIT_LIMIT_OFS) && !$past(reset)
    |-> critLimit == $past(regReq.wdata))
    else $error("limit write lost");
  AST_ALERT_ONE: assert property (convResult.valid && (convResult.high || convResult.low) && cfg[7] == 0
    && !cfg[0] ##1 !cfg[7] && !cfg[0] |=> alertOe)
    else $error("alert missing");
  AST_MASK: assert property ($past(cfg[7]) |-> !alertOe)
    else $error("masked alert driven");
endmodule : fmc_config_tach_assertions
bind fmc_config_tach fmc_config_tach_assertions #(.TICK_DIV(TICK_DIV)) fmc_config_tach_assertions_inst (.clk, .reset,
  .regReq, .regRdata, .convStart, .convResult, .pwmRaw, .pwmPolarity, .pwmOut, .alertOe, .critLimit);

/* fmc_partner.sv */
`timescale 1ns/100ps
module fmc_partner
  import fmc_pkg::*;
#(
  parameter int CONV_DELAY = 10,
  parameter int TACH_HALF = 20
) (
  input logic clk,
  input logic convStart,
  input logic [1:0] verdict,
  output fmc_conv_result_t convResult,
  output logic tachPin
);
  int left = -1;
  int t = 0;
  initial convResult = '0;
  initial tachPin = 1'b0;
  // slow engine: result long after the start
  always @(posedge clk) begin
    convResult <= '0;
    if (convStart) left <= CONV_DELAY;
    else if (left == 0) begin
      convResult <= '{1'b1, verdict[1], verdict[0]};
      left <= -1;
    end else if (left > 0) left <= left - 1;
  end
  always @(posedge clk) begin
    t <= (t == 2 * TACH_HALF - 1) ? 0 : t + 1;
    tachPin <= (t < TACH_HALF);
  end
endmodule : fmc_partner

/* fmc_config_tach_bench.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED %0t got %h expected %h", $time, g, e); end end
module fmc_config_tach_bench;
  import fmc_pkg::*;
  logic clk = 0, reset = 1, pwmRaw = 0, pwmPolarity = 0, regRvalid, convStart, pwmOut, alertOut, alertOe, tachPin;
  logic [7:0] regRdata, critLimit;
  logic [1:0] verdict = 2'h0;
  fmc_reg_req_t regReq = '0;
  fmc_conv_result_t convResult;
  int errors = 0, numChecks = 0, starts = 0, dones = 0, n;
  fmc_config_tach #(.TICK_DIV(2)) fmc_config_tach_inst (.clk, .reset, .regReq, .regRdata, .regRvalid, .convStart,
    .convResult, .tachPin, .pwmRaw, .pwmPolarity, .pwmOut, .alertOut, .alertOe, .critLimit);
  fmc_partner fmc_partner_inst (.clk, .convStart, .verdict, .convResult, .tachPin);
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    starts += convStart;
    dones += convResult.valid;
  end
  task automatic wrap_up();
    if (errors == 0 && numChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) regReq <= '{1'b1, 1'b0, a, d};
    @(negedge clk) regReq <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) regReq <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk) regReq <= '0;
    // regRvalid stands only for the cycle after the read edge
    `CHK(regRvalid, 1'b1)
    `CHK(regRdata, e)
  endtask : rd
  task automatic waitDone(input int k);
    int lim = 0;
    while (dones < k && lim < 400) begin
      @(negedge clk);
      lim++;
    end
    if (dones < k) begin
      errors++;
      wrap_up();
    end
  endtask : waitDone
  initial begin
    repeat (6) @(negedge clk);
    reset <= 0;
    repeat (100) @(negedge clk);
    `CHK(critLimit, CRIT_LIMIT_RESET)
    rd(CONFIG_OFS, CONFIG_RESET);
    rd(TACH_HIGH_OFS, 8'h00);
    rd(TACH_LOW_OFS, 8'hfc);
    rd(TACH_HIGH_OFS, 8'hff);
    wr(CONFIG_OFS, 8'h18);
    rd(CONFIG_OFS, 8'h00);
    wr(CRIT_LIMIT_OFS, 8'h50);
    `CHK(critLimit, 8'h6e)
    wr(CONFIG_OFS, 8'h02);
    wr(CRIT_LIMIT_OFS, 8'h50);
    wr(CRIT_LIMIT_OFS, 8'h51);
    `CHK(critLimit, 8'h51)
    verdict <= 2'b10;
    waitDone(dones + 2);
    repeat (3) @(negedge clk);
    `CHK(alertOe, 1'b1)
    wr(CONFIG_OFS, 8'h80);
    @(negedge clk);
    `CHK(alertOe, 1'b0)
    `CHK(alertOut, 1'b0)
    verdict <= 2'b00;
    wr(CONFIG_OFS, 8'h01);
    waitDone(dones + 2);
    verdict <= 2'b01;
    waitDone(dones + 2);
    repeat (3) @(negedge clk);
    `CHK(alertOe, 1'b0)
    waitDone(dones + 1);
    repeat (3) @(negedge clk);
    `CHK(alertOe, 1'b1)
    wr(CONFIG_OFS, 8'h40);
    repeat (30) @(negedge clk);
    n = starts;
    repeat (100) @(negedge clk);
    `CHK(starts, n)
    wr(ONE_SHOT_OFS, 8'ha5);
    repeat (30) @(negedge clk);
    `CHK(starts, n + 1)
    pwmRaw <= 1;
    wr(CONFIG_OFS, 8'h60);
    @(negedge clk);
    `CHK(pwmOut, 1'b0)
    wr(CONFIG_OFS, 8'h40);
    @(negedge clk);
    `CHK(pwmOut, 1'b1)
    // 40-clock period, tick of 2, default select counts by 4
    wr(CONFIG_OFS, 8'h04);
    repeat (200) @(negedge clk);
    rd(TACH_LOW_OFS, 8'h40);
    rd(TACH_HIGH_OFS, 8'h01);
    // five edges at a step of one span four periods, so the count stays the same
    wr(TACH_LOW_OFS, 8'h03);
    repeat (400) @(negedge clk);
    rd(TACH_LOW_OFS, 8'h43);
    rd(TACH_HIGH_OFS, 8'h01);
    wrap_up();
  end
endmodule : fmc_config_tach_bench
